// *** rtl/wss_pkg.sv ***
// Purpose: Shared constants and types for the waveform sequence slot block.
// Assumes: One 25 MHz clock; registers reached by a simple byte port.
// Notes: Delay slots count in 10 ms ticks derived from the clock.
`default_nettype none
package wss_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int DELAY_UNIT_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h0F;
  localparam logic [7:0] ADDR_SLOT_SECOND = 8'h10;
  localparam logic [7:0] ADDR_SLOT_SEVEN = 8'h15;
  localparam logic [7:0] ADDR_SLOT_EIGHT = 8'h16;
  localparam logic [7:0] ADDR_LOOP_LOW = 8'h17;
  localparam logic [7:0] ADDR_LOOP_HIGH = 8'h18;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] LOOP_RESET = 8'h00;
  localparam int START_BIT = 0;
  localparam int WAIT_BIT = 7;
  localparam int SLOT_COUNT = 8;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [6:0] ZERO_ID = 7'h00;

  typedef struct packed {
    logic delay_flag;
    logic [6:0] value;
  } wss_slot_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wss_req_t;

  typedef enum {WSS_IDLE, WSS_FETCH, WSS_PLAY, WSS_WAIT, WSS_NEXT} wss_state_t;
endpackage : wss_pkg
`default_nettype wire

// *** rtl/wss_tick.sv ***
// Purpose: Divider giving a one-cycle pulse every delay unit.
// Assumes: Runs only while enabled; restarts from zero when disabled.
// Notes: The pulse period is TICK_CYCLES clocks.
`default_nettype none
module wss_tick (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  output logic tick
);
  import wss_pkg::*;
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
  logic [19:0] count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 20'h0_0000;
    end else if (!enable || count == TICK_LAST) begin
      count <= 20'h0_0000;
    end else begin
      count <= count + 20'h0_0001;
    end
  end

  assign tick = enable && (count == TICK_LAST);
endmodule : wss_tick
`default_nettype wire

// *** rtl/wss_slots.sv ***
// Purpose: Sequence slots seven and eight plus the slot walker.
// Assumes: Slots one to six arrive as a flat input from neighbour logic;
//   the library player answers each waveform request with a done pulse.
// Notes: Register port is a one-cycle read or write strobe.
`default_nettype none
module wss_slots (
  input wire logic clock,
  input wire logic rst_n,
  input wire wss_pkg::wss_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [47:0] low_slots,
  output logic wave_start,
  output logic [6:0] wave_index,
  input wire logic wave_done,
  output logic busy
);
  import wss_pkg::*;

  wss_slot_t slot_seven;
  wss_slot_t slot_eight;
  logic [7:0] loop_low;
  logic [7:0] loop_high;
  logic start_req;
  wss_state_t state;
  logic [2:0] slot_idx;
  logic [1:0] plays_done;
  logic [6:0] delay_left;
  logic tick;
  wss_slot_t cur;
  logic [1:0] cur_loop;
  logic launch;
  logic fetch_stop;
  logic fetch_wait;
  logic fetch_play;
  logic wait_over;
  logic replay;
  logic last_done;
  logic advance;
  wss_slot_t slot_table [SLOT_COUNT];

  genvar g;
  generate
    for (g = 0; g < SLOT_COUNT - 2; g++) begin : g_low
      assign slot_table[g] = wss_slot_t'(low_slots[g*8 +: 8]);
    end
  endgenerate
  assign slot_table[6] = slot_seven;
  assign slot_table[7] = slot_eight;

  assign cur = slot_table[slot_idx];
  assign cur_loop = slot_idx[2] ? loop_high[slot_idx[1:0]*2 +: 2]
                                : loop_low[slot_idx[1:0]*2 +: 2];

  // Slot registers; writes to them while playing take effect next fetch.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_seven <= SLOT_RESET;
      slot_eight <= SLOT_RESET;
      loop_low <= LOOP_RESET;
      loop_high <= LOOP_RESET;
    end else if (req.wr) begin
      if (req.addr == ADDR_SLOT_SEVEN) begin
        slot_seven <= req.wdata;
      end else if (req.addr == ADDR_SLOT_EIGHT) begin
        slot_eight <= req.wdata;
      end else if (req.addr == ADDR_LOOP_LOW) begin
        loop_low <= req.wdata;
      end else if (req.addr == ADDR_LOOP_HIGH) begin
        loop_high <= req.wdata;
      end
    end
  end

  // The start bit is a request strobe; it is not stored and only launches the walker from idle.
  assign start_req = req.wr && req.addr == ADDR_CONTROL
                     && req.wdata[START_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        if (req.addr == ADDR_SLOT_SEVEN) begin
          rdata <= slot_seven;
        end else if (req.addr == ADDR_SLOT_EIGHT) begin
          rdata <= slot_eight;
        end else if (req.addr == ADDR_LOOP_LOW) begin
          rdata <= loop_low;
        end else if (req.addr == ADDR_LOOP_HIGH) begin
          rdata <= loop_high;
        end else if (req.addr == ADDR_CONTROL) begin
          rdata <= {7'h00, busy};
        end else begin
          rdata <= 8'h00;
        end
      end
    end
  end

  wss_tick u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .enable(state == WSS_WAIT),
    .tick(tick)
  );

  // Walker decode, shared by the per-register processes below.
  assign launch = state == WSS_IDLE && start_req;
  assign fetch_stop = state == WSS_FETCH && cur.value == ZERO_ID;
  assign fetch_wait = state == WSS_FETCH && cur.value != ZERO_ID
                      && cur.delay_flag;
  assign fetch_play = state == WSS_FETCH && cur.value != ZERO_ID
                      && !cur.delay_flag;
  assign wait_over = state == WSS_WAIT && tick && delay_left == 7'h01;
  assign replay = state == WSS_NEXT && plays_done != cur_loop;
  assign last_done = state == WSS_NEXT && !replay
                     && slot_idx == LAST_SLOT;
  assign advance = state == WSS_NEXT && !replay && !last_done;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= WSS_IDLE;
    end else begin
      case (state)
        WSS_IDLE: begin
          if (launch) begin
            state <= WSS_FETCH;
          end
        end
        WSS_FETCH: begin
          if (fetch_stop) begin
            state <= WSS_IDLE;
          end else if (fetch_wait) begin
            state <= WSS_WAIT;
          end else begin
            state <= WSS_PLAY;
          end
        end
        WSS_PLAY: begin
          if (wave_done) begin
            state <= WSS_NEXT;
          end
        end
        WSS_WAIT: begin
          if (wait_over) begin
            state <= WSS_NEXT;
          end
        end
        WSS_NEXT: begin
          if (last_done) begin
            state <= WSS_IDLE;
          end else begin
            state <= WSS_FETCH;
          end
        end
        default: begin
          state <= WSS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_idx <= 3'h0;
    end else if (launch) begin
      slot_idx <= 3'h0;
    end else if (advance) begin
      slot_idx <= slot_idx + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      plays_done <= 2'h0;
    end else if (launch || advance) begin
      plays_done <= 2'h0;
    end else if (replay) begin
      plays_done <= plays_done + 2'h1;
    end
  end

  // The divider restarts on entry to a wait, so every unit is a full tick
  // period and the idle lasts exactly the slot value in units.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delay_left <= ZERO_ID;
    end else if (fetch_wait) begin
      delay_left <= cur.value;
    end else if (state == WSS_WAIT && tick) begin
      delay_left <= delay_left - 7'h01;
    end
  end

  // A waveform request is a one-cycle strobe; the index holds after it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wave_start <= 1'b0;
    end else begin
      wave_start <= fetch_play;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wave_index <= ZERO_ID;
    end else if (fetch_play) begin
      wave_index <= cur.value;
    end
  end

  assign busy = (state != WSS_IDLE);
endmodule : wss_slots
`default_nettype wire

// *** bench/wss_slots_monitor.sv ***
// Purpose: Port checks of the slot walker.
// Assumes: low_slots stays steady while busy is high.
// Notes: Full wait lengths are too long for a property.
`default_nettype none
module wss_slots_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire wss_pkg::wss_req_t req,
  input wire logic [47:0] low_slots,
  input wire logic wave_start,
  input wire logic [6:0] wave_index,
  input wire logic wave_done,
  input wire logic busy
);
  import wss_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire logic [6:0] v = low_slots[6:0];
  wire logic w = low_slots[7];
  wire logic go = req.wr && req.addr == ADDR_CONTROL && req.wdata[0];
  property p_go; go && !busy |=> busy; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_id; $rose(busy) && !w && v != 7'h00
    |-> ##[1:3] (wave_start && wave_index == v); endproperty
  a_id: assert property (p_id) else $error("bad first index");
  property p_zero; $rose(busy) && v == 7'h00 |-> ##[1:3] !busy; endproperty
  a_zero: assert property (p_zero) else $error("no stop");
  property p_idle; $rose(busy) && w && v != 7'h00 |=> !wave_start [*8];
  endproperty
  a_idle: assert property (p_idle) else $error("wave in wait");
  property p_hold; $rose(busy) && w && v != 7'h00 |=> busy [*8]; endproperty
  a_hold: assert property (p_hold) else $error("wait cut short");
  property p_next; wave_done || wave_start |=> !wave_start; endproperty
  a_next: assert property (p_next) else $error("early start");
  property p_end; !busy |-> !wave_start; endproperty
  a_end: assert property (p_end) else $error("start when idle");
  property p_idx; !wave_start |-> $stable(wave_index); endproperty
  a_idx: assert property (p_idx) else $error("index moved");
endmodule : wss_slots_monitor
bind wss_slots wss_slots_monitor i_wss_slots_monitor (.clock, .rst_n, .req,
  .low_slots, .wave_start, .wave_index, .wave_done, .busy);
`default_nettype wire

// *** bench/wss_slots_tb_top.sv ***
// Purpose: Self-checking bench of the slot walker.
// Assumes: The bench answers each waveform one cycle after its start.
// Notes: A wait slot lasts 250000 cycles, so only its start is seen.
`default_nettype none
module wss_slots_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wss_pkg::*;
  logic clock = 0;
  logic rst_n;
  logic wave_done = 0;
  logic [47:0] low_slots = '0;
  wss_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid, wave_start, busy;
  logic [6:0] wave_index;
  logic [63:0] s;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int t;
  wss_slots i_wss_slots (.clock, .rst_n, .req, .rdata, .rvalid, .low_slots,
    .wave_start, .wave_index, .wave_done, .busy);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Idle cycle after each access so req never changes twice in a step.
  task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
    req = '{wr, !wr, a, d};
    @(posedge clock) #1 req = '0;
    chk("rvalid", {7'h00, !wr}, {7'h00, rvalid});
    @(posedge clock) #1;
    chk("rvalid", 8'h00, {7'h00, rvalid});
  endtask : acc
  task automatic run(logic [63:0] v, logic [15:0] lp);
    int q[$];
    int k;
    low_slots = v[47:0];
    acc(1, 8'h15, v[55:48]);
    acc(1, 8'h16, v[63:56]);
    acc(1, 8'h17, lp[7:0]);
    acc(1, 8'h18, lp[15:8]);
    for (int i = 0; i < 8 && v[i*8+:7] != 7'h00; i++)
      repeat (lp[i*2+:2] + 1) q.push_back(v[i*8+:7]);
    acc(1, 8'h0C, 8'h01);
    foreach (q[j]) begin
      k = 0;
      while (wave_start !== 1'b1 && k++ < 50) @(posedge clock) #1;
      chk("wave_start", 8'h01, {7'h00, wave_start});
      chk("wave_index", 8'(q[j]), {1'b0, wave_index});
      @(posedge clock) #1 wave_done = 1;
      @(posedge clock) #1 wave_done = 0;
    end
    repeat (6) @(posedge clock);
    #1 chk("busy", 8'h00, {7'h0, busy});
  endtask : run
  task automatic do_reset();
    rst_n = 0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1;
  endtask : do_reset
  initial begin
    void'($urandom(32'h09d4_fa98));
    do_reset();
    for (int a = 8'h15; a <= 8'h18; a++) begin
      acc(0, 8'(a), 8'h00);
      chk("rdata", 8'h00, rdata);
    end
    s = {$urandom, $urandom} & 64'h7f7f_7f7f_7f7f_7f7f;
    s = s | 64'h0101_0101_0101_0101;
    acc(1, 8'h16, s[7:0]);
    acc(0, 8'h16, 8'h00);
    chk("rdata", s[7:0], rdata);
    acc(0, 8'h0F, 8'h00);
    chk("rdata", 8'h00, rdata);
    $display("register test done");
    run(s, 16'($urandom));
    run(s & ~64'h00ff_0000, 16'($urandom));
    run(s & ~64'h7f, 16'h0000);
    $display("sequence test done");
    low_slots = 48'h81;
    acc(1, 8'h0C, 8'h01);
    t = 0;
    repeat (1000) @(posedge clock) #1 t += (wave_start !== 1'b0);
    chk("starts", 8'h00, 8'(t));
    chk("busy", 8'h01, {7'h0, busy});
    acc(0, 8'h0C, 8'h00);
    chk("rdata", 8'h01, rdata);
    do_reset();
    chk("busy", 8'h00, {7'h0, busy});
    acc(0, 8'h16, 8'h00);
    chk("rdata", 8'h00, rdata);
    $display("wait test done");
    stop_test();
  end
endmodule : wss_slots_tb_top
`default_nettype wire
